// >>> shared/ncotcs_map.vh
`ifndef NCOTCS_MAP_VH
`define NCOTCS_MAP_VH

// Register offsets
`define NCOTCS_GPIO_CFG0_ADDR 16'h0040
`define NCOTCS_GPIO_CFG1_ADDR 16'h0041
`define NCOTCS_GPIO_CFG2_ADDR 16'h0042
`define NCOTCS_SYNC_CTRL_ADDR 16'h0300
`define NCOTCS_CHSEL_CTRL_ADDR 16'h0314
`define NCOTCS_FTW_BASE_ADDR 16'h0380
`define NCOTCS_POW_BASE_ADDR 16'h0386
`define NCOTCS_MAW_BASE_ADDR 16'h038C
`define NCOTCS_MBW_BASE_ADDR 16'h0392
`define NCOTCS_FTW_INDEX_ADDR 16'h0398
`define NCOTCS_STATUS_ADDR 16'h0399

// Field positions and codes
`define NCOTCS_SOFT_RESET_BIT 4
`define NCOTCS_GPIO_SEL_CODE 3'h6
`define NCOTCS_GPIO_ROUTE_CODE 4'h0
`define NCOTCS_MODE_REG 4'h0
`define NCOTCS_MODE_LVL_LO 4'h1
`define NCOTCS_MODE_LVL_HI 4'h6
`define NCOTCS_MODE_EDGE_LO 4'h8
`define NCOTCS_MODE_EDGE_HI 4'hB

// Reset values
`define NCOTCS_CHSEL_CTRL_RST 8'h00
`define NCOTCS_SYNC_CTRL_RST 8'h00
`define NCOTCS_GPIO_CFG_RST 8'h00

`endif

// >>> hw/ncotcs_chansel.v
`timescale 1ns/1ps
`include "ncotcs_map.vh"

module ncotcs_chansel (
  input wire clk_sys,
  input wire rstn,
  input wire [3:0] gpio_in,
  input wire [3:0] gpio_used,
  input wire [3:0] sel_mode,
  input wire [3:0] sel_low,
  input wire cnt_clr,
  output reg [3:0] chan_q
);

  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  reg [3:0] prev_q;
  reg [3:0] cnt_q;
  reg [3:0] lvl;
  reg [3:0] pins;
  reg [3:0] chan_d;
  reg edge_pin;
  wire [1:0] rot;

  // Two-stage synchroniser for selection pins
  always @(posedge clk_sys) begin
    if (!rstn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      prev_q <= 4'h0;
    end else begin
      sync1_q <= gpio_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  assign rot = sel_mode[2] ? sel_mode[1:0] - 2'h1 : sel_mode[1:0] - 2'h1;

  always @* begin
    pins = sync2_q & gpio_used;
    if (sel_mode >= 4'h5) begin
      pins = {pins[0], pins[1], pins[2], pins[3]};
    end
    case (rot)
      2'h0: lvl = pins;
      2'h1: lvl = {pins[2:0], pins[3]};
      2'h2: lvl = {pins[1:0], pins[3:2]};
      2'h3: lvl = {pins[0], pins[3:1]};
      default: lvl = pins;
    endcase
    edge_pin = sync2_q[sel_mode[1:0]] & ~prev_q[sel_mode[1:0]] & gpio_used[sel_mode[1:0]];
  end

  // Edge-mode counter with wrap point
  always @(posedge clk_sys) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
    end else if (cnt_clr) begin
      cnt_q <= 4'h0;
    end else if (sel_mode >= `NCOTCS_MODE_EDGE_LO && sel_mode <= `NCOTCS_MODE_EDGE_HI
                 && edge_pin) begin
      cnt_q <= (cnt_q >= sel_low) ? 4'h0 : cnt_q + 4'h1;
    end
  end

  always @* begin
    if (sel_mode >= `NCOTCS_MODE_LVL_LO && sel_mode <= `NCOTCS_MODE_LVL_HI) begin
      chan_d = lvl;
    end else if (sel_mode >= `NCOTCS_MODE_EDGE_LO && sel_mode <= `NCOTCS_MODE_EDGE_HI) begin
      chan_d = cnt_q;
    end else begin
      chan_d = sel_low;
    end
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      chan_q <= 4'h0;
    end else begin
      chan_q <= chan_d;
    end
  end

endmodule

// >>> hw/ncotcs_top.v
// Operation
// - zero numerator disables fractional modulus logic
// - tuning and phase writes anytime, phase deterministic
// - each oscillator has 48-bit phase offset
// - coherent mode frequency is tuning over 2^48
// - coherent retune never resets phase state
// - sixteen shadow tuning channels
// - exactly one channel active, pins or register
// - three modes: level, edge, register
// - level mode follows pins, unassigned read low
// - mode 1 to 6 selects level ordering
// - mode 8 to B selects edge pin
// - rising edge advances channel counter
// - counter clears on sync event or soft reset
// - lower nibble sets edge wrap channel
// - register mode takes channel from register
// - mode zero uses lower nibble as channel
// - index register steers tuning word writes
// - soft reset set then cleared zeroes accumulator
`timescale 1ns/1ps
`include "ncotcs_map.vh"

module ncotcs_top (
  input wire clk_sys,
  input wire rstn,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire sysref,
  input wire [3:0] gpio_in,
  output reg [7:0] reg_rdata_q,
  output reg [3:0] active_chan_q,
  output reg [47:0] nco_phase_q
);

  reg [47:0] ftw_mem [0:15];
  reg [47:0] pow_mem [0:15];
  reg [47:0] maw_q;
  reg [47:0] mbw_q;
  reg [47:0] frac_q;
  reg [47:0] acc_q;
  reg [3:0] ftw_idx_q;
  reg [7:0] ctrl_q;
  reg [7:0] sync_q;
  reg [7:0] gcfg0_q;
  reg [7:0] gcfg1_q;
  reg [7:0] gcfg2_q;
  reg [47:0] frac_sum;
  reg carry;
  reg [7:0] rd_d;
  wire [3:0] chan;
  wire [3:0] gpio_used;
  wire soft_rst_fall;
  wire sync_evt;
  wire [15:0] ftw_off;
  wire [15:0] pow_off;
  wire [47:0] ftw_act;
  wire [47:0] pow_act;
  wire [15:0] maw_off;
  wire [15:0] mbw_off;
  wire maw_zero;
  wire [47:0] carry_ext;
  integer i;

  // Pin assignment decode
  assign gpio_used[0] = gcfg2_q[2:0] == `NCOTCS_GPIO_SEL_CODE;
  assign gpio_used[1] = (gcfg0_q[2:0] == `NCOTCS_GPIO_SEL_CODE) &&
                        (gcfg1_q[3:0] == `NCOTCS_GPIO_ROUTE_CODE);
  assign gpio_used[2] = (gcfg0_q[5:3] == `NCOTCS_GPIO_SEL_CODE) &&
                        (gcfg1_q[7:4] == `NCOTCS_GPIO_ROUTE_CODE);
  assign gpio_used[3] = gcfg2_q[5:3] == `NCOTCS_GPIO_SEL_CODE;

  // Soft reset acts on the clearing write
  assign soft_rst_fall = reg_wr_en && reg_addr == `NCOTCS_SYNC_CTRL_ADDR &&
                         sync_q[`NCOTCS_SOFT_RESET_BIT] &&
                         !reg_wdata[`NCOTCS_SOFT_RESET_BIT];
  assign sync_evt = soft_rst_fall || (sysref && sync_q[1:0] != 2'h0);

  assign ftw_off = reg_addr - `NCOTCS_FTW_BASE_ADDR;
  assign pow_off = reg_addr - `NCOTCS_POW_BASE_ADDR;
  assign ftw_act = ftw_mem[chan];
  assign pow_act = pow_mem[chan];

  // Modulus byte offsets and carry widened to the accumulator
  assign maw_off = reg_addr - `NCOTCS_MAW_BASE_ADDR;
  assign mbw_off = reg_addr - `NCOTCS_MBW_BASE_ADDR;
  assign maw_zero = maw_q == 48'h000000000000;
  assign carry_ext = {47'h0, carry};

  // Selector for the active shadow channel
  ncotcs_chansel u_chansel (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .gpio_in(gpio_in),
    .gpio_used(gpio_used),
    .sel_mode(ctrl_q[7:4]),
    .sel_low(ctrl_q[3:0]),
    .cnt_clr(sync_evt),
    .chan_q(chan)
  );

  // Register writes
  always @(posedge clk_sys) begin
    if (!rstn) begin
      maw_q <= 48'h000000000000;
      mbw_q <= 48'h000000000001;
      ftw_idx_q <= 4'h0;
      ctrl_q <= `NCOTCS_CHSEL_CTRL_RST;
      sync_q <= `NCOTCS_SYNC_CTRL_RST;
      gcfg0_q <= `NCOTCS_GPIO_CFG_RST;
      gcfg1_q <= `NCOTCS_GPIO_CFG_RST;
      gcfg2_q <= `NCOTCS_GPIO_CFG_RST;
      for (i = 0; i < 16; i = i + 1) begin
        ftw_mem[i] <= 48'h000000000000;
        pow_mem[i] <= 48'h000000000000;
      end
    end else if (reg_wr_en) begin
      case (reg_addr)
        `NCOTCS_GPIO_CFG0_ADDR: gcfg0_q <= reg_wdata;
        `NCOTCS_GPIO_CFG1_ADDR: gcfg1_q <= reg_wdata;
        `NCOTCS_GPIO_CFG2_ADDR: gcfg2_q <= reg_wdata;
        `NCOTCS_SYNC_CTRL_ADDR: sync_q <= reg_wdata;
        `NCOTCS_CHSEL_CTRL_ADDR: ctrl_q <= reg_wdata;
        `NCOTCS_FTW_INDEX_ADDR: ftw_idx_q <= reg_wdata[3:0];
        default: begin
        end
      endcase
      // Tuning and phase bytes land in the indexed shadow channel
      if (ftw_off < 16'h0006) begin
        ftw_mem[ftw_idx_q][ftw_off[2:0]*8 +: 8] <= reg_wdata;
      end
      if (pow_off < 16'h0006) begin
        pow_mem[ftw_idx_q][pow_off[2:0]*8 +: 8] <= reg_wdata;
      end
      if (maw_off < 16'h0006) begin
        maw_q[maw_off[2:0]*8 +: 8] <= reg_wdata;
      end
      if (mbw_off < 16'h0006) begin
        mbw_q[mbw_off[2:0]*8 +: 8] <= reg_wdata;
      end
    end
  end

  // Fractional modulus step
  always @* begin
    frac_sum = frac_q + maw_q;
    carry = 1'b0;
    if (!maw_zero && frac_sum >= mbw_q) begin
      frac_sum = frac_sum - mbw_q;
      carry = 1'b1;
    end
  end

  // Phase accumulator; retuning never clears it
  always @(posedge clk_sys) begin
    if (!rstn || sync_evt) begin
      acc_q <= 48'h000000000000;
      frac_q <= 48'h000000000000;
      nco_phase_q <= 48'h000000000000;
    end else begin
      if (maw_zero) begin
        acc_q <= acc_q + ftw_act;
        frac_q <= 48'h000000000000;
      end else begin
        acc_q <= acc_q + ftw_act + carry_ext;
        frac_q <= frac_sum;
      end
      nco_phase_q <= acc_q + pow_act;
    end
  end

  // Read mux
  always @* begin
    rd_d = 8'h00;
    case (reg_addr)
      `NCOTCS_GPIO_CFG0_ADDR: rd_d = gcfg0_q;
      `NCOTCS_GPIO_CFG1_ADDR: rd_d = gcfg1_q;
      `NCOTCS_GPIO_CFG2_ADDR: rd_d = gcfg2_q;
      `NCOTCS_SYNC_CTRL_ADDR: rd_d = sync_q;
      `NCOTCS_CHSEL_CTRL_ADDR: rd_d = ctrl_q;
      `NCOTCS_FTW_INDEX_ADDR: rd_d = {4'h0, ftw_idx_q};
      `NCOTCS_STATUS_ADDR: rd_d = {4'h0, chan};
      default: rd_d = 8'h00;
    endcase
    if (ftw_off < 16'h0006) begin
      rd_d = ftw_mem[ftw_idx_q][ftw_off[2:0]*8 +: 8];
    end
    if (pow_off < 16'h0006) begin
      rd_d = pow_mem[ftw_idx_q][pow_off[2:0]*8 +: 8];
    end
    // Modulus words read back as written
    if (maw_off < 16'h0006) begin
      rd_d = maw_q[maw_off[2:0]*8 +: 8];
    end
    if (mbw_off < 16'h0006) begin
      rd_d = mbw_q[mbw_off[2:0]*8 +: 8];
    end
  end

  // Output registers
  always @(posedge clk_sys) begin
    if (!rstn) begin
      reg_rdata_q <= 8'h00;
      active_chan_q <= 4'h0;
    end else begin
      if (reg_rd_en) begin
        reg_rdata_q <= rd_d;
      end
      active_chan_q <= chan;
    end
  end

endmodule

// >>> verif/ncotcs_top_assertions.sv
`timescale 1ns/1ps
module ncotcs_chk (
  input wire clk_sys,
  input wire rstn,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire sysref,
  input wire [3:0] gpio_in,
  input wire [7:0] reg_rdata_q,
  input wire [3:0] active_chan_q,
  input wire [47:0] nco_phase_q
);
  logic [7:0] ctl_q;
  logic sr_q;
  wire wc = reg_wr_en && reg_addr == 16'h0314;
  wire ws = reg_wr_en && reg_addr == 16'h0300;
  wire edg = ctl_q[7:6] == 2'b10;
  wire lvl = ctl_q[7:4] != 4'h0 && ctl_q[7:4] < 4'h7;
  // Shadow copies of the selector control and soft reset bit
  always @(posedge clk_sys) begin
    ctl_q <= !rstn ? 8'h00 : wc ? reg_wdata : ctl_q;
    sr_q <= !rstn ? 1'b0 : ws ? reg_wdata[4] : sr_q;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_reg_chan: assert property ((!wc)[*6] ##0 (!edg && !lvl)
    |-> active_chan_q == ctl_q[3:0]) else $error("reg channel");
  a_edge_wrap: assert property ((!wc)[*6] ##0 edg
    |-> active_chan_q <= ctl_q[3:0]) else $error("edge wrap");
  a_edge_step: assert property ((!wc)[*6] ##0 (edg && $changed(active_chan_q))
    |-> active_chan_q == $past(active_chan_q) + 4'h1 || active_chan_q == 4'h0)
    else $error("edge step");
  a_soft_reset_zero: assert property (ws && !reg_wdata[4] && sr_q
    |=> nco_phase_q == 48'h0) else $error("soft reset");
  a_chan_stable: assert property ((!reg_wr_en && !sysref && $stable(gpio_in))[*6]
    |-> $stable(active_chan_q)) else $error("channel moved");
  a_level_low: assert property ((!wc && gpio_in == 4'h0)[*6] ##0 lvl
    |-> active_chan_q == 4'h0) else $error("level low");
  a_status_width: assert property (reg_rd_en && reg_addr == 16'h0399
    |=> reg_rdata_q[7:4] == 4'h0) else $error("status");
  a_phase_linear: assert property ((!reg_wr_en && !sysref && $stable(active_chan_q))[*6]
    |-> (nco_phase_q - $past(nco_phase_q)) - ($past(nco_phase_q) - $past(nco_phase_q, 2))
    inside {48'h0, 48'h1, 48'hFFFF_FFFF_FFFF}) else $error("phase step");
  c_edge: cover property (edg && $changed(active_chan_q));
  c_sreset: cover property (ws && sr_q);
  c_level: cover property (lvl && active_chan_q != 4'h0);
endmodule
bind ncotcs_top ncotcs_chk ncotcs_chk_i (.*);

// >>> verif/ncotcs_host.sv
`timescale 1ns/1ps
module ncotcs_host (
  input wire clk_sys,
  input wire [7:0] reg_rdata_q,
  output logic reg_wr_en = 1'b0,
  output logic reg_rd_en = 1'b0,
  output logic [15:0] reg_addr = 16'h0000,
  output logic [7:0] reg_wdata = 8'h00,
  output logic sysref = 1'b0,
  output logic [3:0] gpio_in = 4'h0
);
  // Idle bus shows inverted values so stale data is never mistaken
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // Read data is registered on the read edge and taken one half cycle later
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk_sys);
    d = reg_rdata_q;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
  endtask
  task automatic wr48(input logic [15:0] a, input logic [47:0] v);
    for (int i = 0; i < 6; i++) begin
      wr(a + 16'(i), v[8*i +: 8]);
    end
  endtask
  // Pin pulses hold each level three cycles
  task automatic pulse(input int b);
    @(negedge clk_sys);
    gpio_in[b] = 1'b1;
    repeat (3) @(negedge clk_sys);
    gpio_in[b] = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic sync;
    @(negedge clk_sys);
    sysref = 1'b1;
    @(negedge clk_sys);
    sysref = 1'b0;
  endtask
endmodule

// >>> verif/ncotcs_top_tb.sv
`timescale 1ns/1ps
module ncotcs_top_tb;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  wire reg_wr_en;
  wire reg_rd_en;
  wire sysref;
  wire [15:0] reg_addr;
  wire [7:0] reg_wdata;
  wire [7:0] reg_rdata_q;
  wire [3:0] gpio_in;
  wire [3:0] active_chan_q;
  wire [47:0] nco_phase_q;
  int fail_count = 0;
  int checks = 0;
  int c = 0;
  logic [3:0] g;
  logic [7:0] b;
  logic [47:0] f;
  logic [47:0] s;
  ncotcs_top ncotcs_top_i (.*);
  ncotcs_host ncotcs_host_i (.*);
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic w(input logic [15:0] a, input logic [7:0] v);
    ncotcs_host_i.wr(a, v);
  endtask
  task automatic span(input int n, output logic [47:0] v);
    logic [47:0] p;
    repeat (6) @(negedge clk_sys);
    p = nco_phase_q;
    repeat (n) @(negedge clk_sys);
    v = nco_phase_q - p;
  endtask
  // Pin ordering: modes 5 and 6 reverse, then rotate left by mode-1
  function automatic logic [3:0] lvl(input int m, input logic [3:0] v);
    logic [3:0] r;
    r = (m > 4) ? {v[0], v[1], v[2], v[3]} : v;
    return (r << (m - 1) % 4) | (r >> (4 - (m - 1) % 4));
  endfunction
  initial begin
    repeat (30000) @(posedge clk_sys);
    fail_count++;
    wrap_up;
  end
  initial begin
    int mt[6] = '{0, 7, 12, 13, 14, 15};
    void'($urandom(32'h31e73a55));
    repeat (2) @(negedge clk_sys);
    rstn = 1'b1;
    for (int i = 0; i < 6; i++) begin
      g = 4'($urandom);
      w(16'h0314, {mt[i][3:0], g});
      repeat (6) @(negedge clk_sys);
      chk(active_chan_q, g);
      ncotcs_host_i.rd(16'h0314, b);
      chk(b, {mt[i][3:0], g});
    end
    w(16'h0040, 8'h36);
    w(16'h0041, 8'h00);
    w(16'h0042, 8'h36);
    for (int m = 1; m < 7; m++) begin
      g = 4'($urandom);
      ncotcs_host_i.gpio_in = g;
      w(16'h0314, {m[3:0], 4'h0});
      repeat (6) @(negedge clk_sys);
      chk(active_chan_q, lvl(m, g));
    end
    w(16'h0042, 8'h00);
    repeat (6) @(negedge clk_sys);
    chk(active_chan_q, lvl(6, g & 4'h6));
    ncotcs_host_i.gpio_in = 4'h0;
    w(16'h0042, 8'h36);
    repeat (6) @(negedge clk_sys);
    for (int i = 0; i < 13; i++) begin
      if (i % 2 == 0 && i < 8) begin
        w(16'h0300, 8'h10);
        w(16'h0314, {2'b10, 2'(i / 2), 4'h4});
        w(16'h0300, 8'h00);
        c = 0;
      end
      ncotcs_host_i.pulse((i < 6) ? i / 2 : 3);
      c = (c >= 4) ? 0 : c + 1;
      chk(active_chan_q, c);
      ncotcs_host_i.rd(16'h0399, b);
      chk(b, c);
    end
    w(16'h0300, 8'h01);
    ncotcs_host_i.sync;
    repeat (6) @(negedge clk_sys);
    chk(active_chan_q, 0);
    w(16'h0314, 8'h00);
    w(16'h0398, 8'h00);
    f = 48'({$urandom, $urandom});
    ncotcs_host_i.wr48(16'h0380, f);
    span(1, s);
    chk(s, f);
    f = 48'({$urandom, $urandom});
    ncotcs_host_i.wr48(16'h0380, f);
    span(1, s);
    chk(s, f);
    ncotcs_host_i.wr48(16'h038C, 48'h1);
    ncotcs_host_i.wr48(16'h0392, 48'h3);
    w(16'h0300, 8'h10);
    w(16'h0300, 8'h00);
    span(3, s);
    chk(s, 3 * f + 1);
    ncotcs_host_i.wr48(16'h038C, 48'h0);
    w(16'h0300, 8'h10);
    w(16'h0300, 8'h00);
    span(3, s);
    chk(s, 3 * f);
    f = 48'({$urandom, $urandom});
    ncotcs_host_i.wr48(16'h0380, 48'h0);
    ncotcs_host_i.wr48(16'h0386, f);
    w(16'h0300, 8'h10);
    w(16'h0300, 8'h00);
    repeat (6) @(negedge clk_sys);
    chk(nco_phase_q, f);
    for (int i = 0; i < 6; i++) begin
      ncotcs_host_i.rd(16'h0386 + 16'(i), b);
      chk(b, f[8*i +: 8]);
    end
    wrap_up;
  end
endmodule
